// File: irq_enable_timers_stopwatch.sv
// Status interrupt enables, line gates, two macrotick timers and stopwatch.
// Assumes the macrotick, cycle and channel counters come from the protocol
// engine, and i_poc_normal is high in the active or passive normal state.
`include "irq_timers_defs.svh"

module irq_enable_timers_stopwatch #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                        i_clock,
	input  wire logic                        i_rst,
	input  wire logic                        i_wr_en,
	input  wire logic                        i_rd_en,
	input  wire logic [ADDR_WIDTH-1:0]       i_addr,
	input  wire logic [31:0]                 i_wdata,
	output logic      [31:0]                 o_rdata,
	output logic                             o_rvalid,
	input  wire logic [31:0]                 i_status_flag_word,
	input  wire logic [31:0]                 i_status_line_select,
	input  wire logic                        i_poc_normal,
	input  wire logic                        i_macrotick_tick,
	input  wire irq_timers_pkg::macrotick_t  i_macrotick_value,
	input  wire irq_timers_pkg::cycle_t      i_cycle_count,
	input  wire irq_timers_pkg::chan_count_t i_chan_a_count,
	input  wire irq_timers_pkg::chan_count_t i_chan_b_count,
	input  wire logic                        i_stopwatch_trigger_pin,
	output logic                             o_irq_line_zero,
	output logic                             o_irq_line_one,
	output logic                             o_cycle_timer_pulse_out,
	output logic                             o_tick_timer_pulse_out,
	output logic                             o_cycle_timer_flag,
	output logic                             o_tick_timer_flag,
	output logic                             o_stopwatch_event
);
	logic [31:0]                 status_en;
	logic [1:0]                  line_en;
	irq_timers_pkg::macrotick_t  cyc_offset;
	logic [6:0]                  cyc_code;
	logic                        cyc_mode;
	logic                        cyc_run;
	logic                        cyc_spent;
	irq_timers_pkg::macrotick_t  tick_target;
	logic                        tick_mode;
	logic                        tick_run;
	logic                        sw_enable;
	logic                        sw_mode;
	logic                        sw_edge;
	logic                        sw_soft;
	logic                        sw_pin_allow;
	logic                        sw_line0_allow;
	logic                        sw_line1_allow;
	irq_timers_pkg::macrotick_t  captured_macrotick;
	irq_timers_pkg::cycle_t      captured_cycle;
	irq_timers_pkg::chan_count_t chan_a_captured_count;
	irq_timers_pkg::chan_count_t chan_b_captured_count;
	logic                        pin_prev;
	logic                        line0_prev;
	logic                        line1_prev;
	logic [31:0]                 rd_word;
	logic [31:0]                 pending;
	logic                        cyc_fire;
	logic                        cyc_active;
	logic                        tick_fire;
	logic                        pin_edge;
	logic                        hw_trigger;
	logic                        sw_event;
	logic                        wr_cyc;
	logic                        wr_tick;
	logic                        wr_ctrl;
	logic                        ctrl_conflict;

	function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr,
		input logic [7:0] ofs);
		hit = (addr == ADDR_WIDTH'(ofs));
	endfunction

	// The leading one of the code gives the repetition, the bits below it
	// the base cycle; a zero code matches every cycle.
	function automatic logic cycle_match(input logic [6:0] code,
		input irq_timers_pkg::cycle_t cyc);
		logic [5:0] mask;
		mask = 6'h00;
		for (int k = 0; k < 6; k++) begin
			mask[k] = |(code >> (k + 1));
		end
		cycle_match = (((cyc ^ code[5:0]) & mask) == 6'h00);
	endfunction

	assign wr_cyc  = i_wr_en && hit(i_addr, `OFS_CYCLE_TIMER);
	assign wr_tick = i_wr_en && hit(i_addr, `OFS_TICK_TIMER);
	assign wr_ctrl = i_wr_en && hit(i_addr, `OFS_STOPWATCH_CTRL);
	assign ctrl_conflict = i_wdata[`SW_ENABLE_BIT] && i_wdata[`SW_SOFT_BIT];

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			status_en <= `RST_STATUS_EN;
		end else if (i_wr_en && hit(i_addr, `OFS_STATUS_EN_SET)) begin
			status_en <= status_en | (i_wdata & `STATUS_EN_MASK);
		end else if (i_wr_en && hit(i_addr, `OFS_STATUS_EN_CLEAR)) begin
			status_en <= status_en & ~i_wdata;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			line_en <= `RST_LINE_EN;
		end else if (i_wr_en && hit(i_addr, `OFS_LINE_ENABLE)) begin
			line_en <= i_wdata[`LINE_ONE_BIT:`LINE_ZERO_BIT];
		end
	end

	assign pending = i_status_flag_word & status_en;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_irq_line_zero <= 1'b0;
			o_irq_line_one  <= 1'b0;
		end else begin
			o_irq_line_zero <= line_en[`LINE_ZERO_BIT] &&
				|(pending & ~i_status_line_select);
			o_irq_line_one  <= line_en[`LINE_ONE_BIT] &&
				|(pending & i_status_line_select);
		end
	end

	// Configuration is expected only while the timer is stopped.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cyc_offset  <= `RST_OFFSET;
			cyc_code    <= `RST_CODE;
			cyc_mode    <= 1'b0;
			cyc_run     <= 1'b0;
			tick_target <= `RST_OFFSET;
			tick_mode   <= 1'b0;
			tick_run    <= 1'b0;
		end else begin
			if (wr_cyc) begin
				cyc_offset <= i_wdata[`TMR_OFS_MSB:`TMR_OFS_LSB];
				cyc_code   <= i_wdata[`TMR_CODE_MSB:`TMR_CODE_LSB];
				cyc_mode   <= i_wdata[`TMR_MODE_BIT];
				cyc_run    <= i_wdata[`TMR_RUN_BIT];
			end
			if (wr_tick) begin
				tick_target <= i_wdata[`TMR_OFS_MSB:`TMR_OFS_LSB];
				tick_mode   <= i_wdata[`TMR_MODE_BIT];
				tick_run    <= i_wdata[`TMR_RUN_BIT];
			end
		end
	end

	assign cyc_active = cyc_run && i_poc_normal;
	assign cyc_fire = cyc_active && !cyc_spent && i_macrotick_tick &&
		(i_macrotick_value == cyc_offset) &&
		cycle_match(cyc_code, i_cycle_count);

	always_ff @(posedge i_clock) begin
		// A fire in the cycle of a rewrite wins, so that rewrite does not re-arm the shot.
		if (i_rst) begin
			cyc_spent <= 1'b0;
		end else if (cyc_fire && !cyc_mode) begin
			cyc_spent <= 1'b1;
		end else if (wr_cyc) begin
			cyc_spent <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_cycle_timer_pulse_out <= 1'b0;
			o_cycle_timer_flag      <= 1'b0;
		end else begin
			o_cycle_timer_flag <= cyc_fire;
			if (!cyc_active) begin
				o_cycle_timer_pulse_out <= 1'b0;
			end else if (cyc_fire) begin
				o_cycle_timer_pulse_out <= 1'b1;
			end else if (i_macrotick_tick) begin
				o_cycle_timer_pulse_out <= 1'b0;
			end
		end
	end

	macrotick_timer #(
		.COUNT_WIDTH (14)
	) u_tick_timer (
		.i_clock      (i_clock),
		.i_rst        (i_rst),
		.i_tick       (i_macrotick_tick),
		.i_enable     (tick_run && i_poc_normal),
		.i_continuous (tick_mode),
		.i_restart    (wr_tick),
		.i_target     (tick_target),
		.o_pulse      (o_tick_timer_pulse_out),
		.o_fire       (tick_fire)
	);

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_tick_timer_flag <= 1'b0;
		end else begin
			o_tick_timer_flag <= tick_fire;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pin_prev   <= 1'b0;
			line0_prev <= 1'b0;
			line1_prev <= 1'b0;
		end else begin
			pin_prev   <= i_stopwatch_trigger_pin;
			line0_prev <= o_irq_line_zero;
			line1_prev <= o_irq_line_one;
		end
	end

	assign pin_edge = sw_edge ? (i_stopwatch_trigger_pin && !pin_prev) :
		(!i_stopwatch_trigger_pin && pin_prev);
	assign hw_trigger = sw_enable && (
		(sw_pin_allow && pin_edge) ||
		(sw_line0_allow && o_irq_line_zero && !line0_prev) ||
		(sw_line1_allow && o_irq_line_one && !line1_prev));
	assign sw_event = hw_trigger || sw_soft;

	// Hardware clears first; an accepted host write then takes priority.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sw_enable      <= 1'b0;
			sw_mode        <= 1'b0;
			sw_edge        <= 1'b0;
			sw_soft        <= 1'b0;
			sw_pin_allow   <= 1'b0;
			sw_line0_allow <= 1'b0;
			sw_line1_allow <= 1'b0;
		end else begin
			if (sw_event) begin
				sw_soft <= 1'b0;
				if (!sw_mode) begin
					sw_enable <= 1'b0;
				end
			end
			if (wr_ctrl && !ctrl_conflict) begin
				sw_enable      <= i_wdata[`SW_ENABLE_BIT];
				sw_mode        <= i_wdata[`SW_MODE_BIT];
				sw_edge        <= i_wdata[`SW_EDGE_BIT];
				sw_pin_allow   <= i_wdata[`SW_PIN_BIT];
				sw_line0_allow <= i_wdata[`SW_LINE0_BIT];
				sw_line1_allow <= i_wdata[`SW_LINE1_BIT];
				if (!sw_enable) begin
					sw_soft <= i_wdata[`SW_SOFT_BIT];
				end
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			captured_macrotick    <= `RST_OFFSET;
			captured_cycle        <= `RST_CAPT_CYCLE;
			chan_a_captured_count <= `RST_CHAN_COUNT;
			chan_b_captured_count <= `RST_CHAN_COUNT;
			o_stopwatch_event     <= 1'b0;
		end else begin
			o_stopwatch_event <= sw_event;
			if (sw_event) begin
				captured_macrotick    <= i_macrotick_value;
				captured_cycle        <= i_cycle_count;
				chan_a_captured_count <= i_chan_a_count;
				chan_b_captured_count <= i_chan_b_count;
			end
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		if (hit(i_addr, `OFS_STATUS_EN_SET) ||
			hit(i_addr, `OFS_STATUS_EN_CLEAR)) begin
			rd_word = status_en;
		end else if (hit(i_addr, `OFS_LINE_ENABLE)) begin
			rd_word[`LINE_ONE_BIT:`LINE_ZERO_BIT] = line_en;
		end else if (hit(i_addr, `OFS_CYCLE_TIMER)) begin
			rd_word[`TMR_OFS_MSB:`TMR_OFS_LSB]   = cyc_offset;
			rd_word[`TMR_CODE_MSB:`TMR_CODE_LSB] = cyc_code;
			rd_word[`TMR_MODE_BIT]               = cyc_mode;
			rd_word[`TMR_RUN_BIT]                = cyc_run;
		end else if (hit(i_addr, `OFS_TICK_TIMER)) begin
			rd_word[`TMR_OFS_MSB:`TMR_OFS_LSB] = tick_target;
			rd_word[`TMR_MODE_BIT]             = tick_mode;
			rd_word[`TMR_RUN_BIT]              = tick_run;
		end else if (hit(i_addr, `OFS_STOPWATCH_CTRL)) begin
			rd_word[`SW_MT_MSB:`SW_MT_LSB]   = captured_macrotick;
			rd_word[`SW_CYC_MSB:`SW_CYC_LSB] = captured_cycle;
			rd_word[`SW_LINE1_BIT]           = sw_line1_allow;
			rd_word[`SW_LINE0_BIT]           = sw_line0_allow;
			rd_word[`SW_PIN_BIT]             = sw_pin_allow;
			rd_word[`SW_SOFT_BIT]            = sw_soft;
			rd_word[`SW_EDGE_BIT]            = sw_edge;
			rd_word[`SW_MODE_BIT]            = sw_mode;
			rd_word[`SW_ENABLE_BIT]          = sw_enable;
		end else if (hit(i_addr, `OFS_STOPWATCH_COUNTS)) begin
			rd_word[`CH_B_MSB:`CH_B_LSB] = chan_b_captured_count;
			rd_word[`CH_A_MSB:`CH_A_LSB] = chan_a_captured_count;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rdata  <= 32'h00000000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd_en;
			if (i_rd_en) begin
				o_rdata <= rd_word;
			end
		end
	end

	a_enable_set: assert property (@(posedge i_clock) disable iff (i_rst)
		i_wr_en && hit(i_addr, `OFS_STATUS_EN_SET) |=>
		((status_en & $past(i_wdata) & `STATUS_EN_MASK) ==
		($past(i_wdata) & `STATUS_EN_MASK)) &&
		((status_en & ~$past(i_wdata)) == $past(status_en & ~i_wdata)))
		else $error("enable set write wrong");
	a_enable_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		i_wr_en && hit(i_addr, `OFS_STATUS_EN_CLEAR) |=>
		((status_en & $past(i_wdata)) == 32'h00000000))
		else $error("enable clear write wrong");
	a_enable_read: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rd_en && (hit(i_addr, `OFS_STATUS_EN_SET) ||
		hit(i_addr, `OFS_STATUS_EN_CLEAR)) |=> o_rdata == $past(status_en))
		else $error("enable read differs");
	a_line_gate: assert property (@(posedge i_clock) disable iff (i_rst)
		o_irq_line_one |-> $past(line_en[`LINE_ONE_BIT]) &&
		$past(|(pending & i_status_line_select)))
		else $error("line one asserted without gate");
	a_cycle_stop: assert property (@(posedge i_clock) disable iff (i_rst)
		!cyc_active |=> !o_cycle_timer_pulse_out)
		else $error("cycle pulse not low after stop");
	a_cycle_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(o_cycle_timer_pulse_out) |-> o_cycle_timer_flag &&
		$past(i_macrotick_value == cyc_offset))
		else $error("cycle pulse without offset match");
	a_soft_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		sw_soft && !wr_ctrl |=> !sw_soft && o_stopwatch_event)
		else $error("soft trigger not cleared");
	a_conflict_ignore: assert property (@(posedge i_clock) disable iff (i_rst)
		wr_ctrl && ctrl_conflict && !sw_event |=>
		sw_enable == $past(sw_enable) && sw_soft == $past(sw_soft))
		else $error("conflicting write took effect");
	a_single_shot: assert property (@(posedge i_clock) disable iff (i_rst)
		hw_trigger && !sw_mode && !wr_ctrl |=> !sw_enable)
		else $error("single-shot did not clear enable");
	a_capture_value: assert property (@(posedge i_clock) disable iff (i_rst)
		sw_event |=> captured_macrotick == $past(i_macrotick_value) &&
		chan_b_captured_count == $past(i_chan_b_count))
		else $error("capture value wrong");
	a_capture_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		!sw_event |=> $stable(captured_cycle) && $stable(chan_a_captured_count))
		else $error("capture changed without event");

	c_pin_capture: cover property (@(posedge i_clock) disable iff (i_rst)
		sw_enable && sw_pin_allow && pin_edge);
	c_cycle_fire: cover property (@(posedge i_clock) disable iff (i_rst)
		cyc_fire && cyc_mode);
	c_line_trigger: cover property (@(posedge i_clock) disable iff (i_rst)
		hw_trigger && sw_line0_allow && !sw_pin_allow);
	c_soft_capture: cover property (@(posedge i_clock) disable iff (i_rst)
		sw_soft ##1 o_stopwatch_event);
endmodule // irq_enable_timers_stopwatch

// File: irq_timers_defs.svh
// Register offsets, field positions and reset values of the event block.
// Assumes byte addressing on the host port, one aligned 32-bit word each.
`ifndef IRQ_TIMERS_DEFS_SVH
`define IRQ_TIMERS_DEFS_SVH

`define OFS_STATUS_EN_SET     8'h38
`define OFS_STATUS_EN_CLEAR   8'h3c
`define OFS_LINE_ENABLE       8'h40
`define OFS_CYCLE_TIMER       8'h44
`define OFS_TICK_TIMER        8'h48
`define OFS_STOPWATCH_CTRL    8'h4c
`define OFS_STOPWATCH_COUNTS  8'h50

`define STATUS_EN_MASK        32'h0203ffff
`define RST_STATUS_EN         32'h00000000
`define RST_LINE_EN           2'h0
`define RST_OFFSET            14'h0000
`define RST_CODE              7'h00
`define RST_CAPT_CYCLE        6'h00
`define RST_CHAN_COUNT        11'h000

`define LINE_ZERO_BIT         0
`define LINE_ONE_BIT          1

`define TMR_RUN_BIT           0
`define TMR_MODE_BIT          1
`define TMR_OFS_LSB           16
`define TMR_OFS_MSB           29
`define TMR_CODE_LSB          8
`define TMR_CODE_MSB          14

`define SW_ENABLE_BIT         0
`define SW_MODE_BIT           1
`define SW_EDGE_BIT           2
`define SW_SOFT_BIT           3
`define SW_PIN_BIT            4
`define SW_LINE0_BIT          5
`define SW_LINE1_BIT          6
`define SW_MT_LSB             16
`define SW_MT_MSB             29
`define SW_CYC_LSB            8
`define SW_CYC_MSB            13

`define CH_B_LSB              16
`define CH_B_MSB              26
`define CH_A_LSB              0
`define CH_A_MSB              10

`endif

// File: irq_timers_pkg.sv
// Types shared by the event block and its macrotick count timer.
// Assumes nothing beyond the defines header.
package irq_timers_pkg;
	typedef logic [13:0] macrotick_t;
	typedef logic [5:0]  cycle_t;
	typedef logic [10:0] chan_count_t;
	typedef enum logic [1:0] {TICK_STOPPED, TICK_COUNT, TICK_SPENT} tick_state_e;
endpackage

// File: macrotick_timer.sv
// Macrotick count timer with a one-macrotick pulse output.
// Assumes i_tick is a one-cycle pulse per macrotick.
module macrotick_timer #(
	parameter int COUNT_WIDTH = 14
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst,
	input  wire logic                   i_tick,
	input  wire logic                   i_enable,
	input  wire logic                   i_continuous,
	input  wire logic                   i_restart,
	input  wire logic [COUNT_WIDTH-1:0] i_target,
	output logic                        o_pulse,
	output logic                        o_fire
);
	irq_timers_pkg::tick_state_e state;
	logic [COUNT_WIDTH-1:0]      count;
	logic [COUNT_WIDTH-1:0]      next_count;
	logic                        fire;

	assign next_count = count + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
	assign fire = (state == irq_timers_pkg::TICK_COUNT) && i_enable &&
		i_tick && (next_count == i_target);

	// Counting holds while the protocol is outside normal operation.
	always_ff @(posedge i_clock) begin
		if (i_rst || i_restart) begin
			state <= irq_timers_pkg::TICK_STOPPED;
			count <= '0;
		end else begin
			case (state)
				irq_timers_pkg::TICK_STOPPED: begin
					if (i_enable) begin
						state <= irq_timers_pkg::TICK_COUNT;
					end
				end
				irq_timers_pkg::TICK_COUNT: begin
					if (fire) begin
						count <= '0;
						if (!i_continuous) begin
							state <= irq_timers_pkg::TICK_SPENT;
						end
					end else if (i_enable && i_tick) begin
						count <= next_count;
					end
				end
				default: begin
					state <= irq_timers_pkg::TICK_SPENT;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_pulse <= 1'b0;
			o_fire  <= 1'b0;
		end else begin
			o_fire <= fire;
			if (!i_enable) begin
				o_pulse <= 1'b0;
			end else if (fire) begin
				o_pulse <= 1'b1;
			end else if (i_tick) begin
				o_pulse <= 1'b0;
			end
		end
	end

	a_tick_stop_low: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_enable |=> !o_pulse)
		else $error("tick pulse not low after stop");
	a_tick_fire_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(o_pulse) |-> o_fire && $past(next_count == i_target))
		else $error("tick pulse rose without reaching the count");
	a_tick_single: assert property (@(posedge i_clock) disable iff (i_rst)
		o_fire && !$past(i_continuous) && !$past(i_restart)
		|-> state == irq_timers_pkg::TICK_SPENT)
		else $error("single-shot tick timer did not stop");
	c_tick_fire: cover property (@(posedge i_clock) disable iff (i_rst)
		o_fire && i_continuous);
endmodule // macrotick_timer

// File: proto_engine_model.sv
// Protocol engine stand-in: macrotick tick, cycle and channel counters.
// Assumes the bench raises i_hold to freeze every count for captures.
module proto_engine_model #(
	parameter int TICK_DIV     = 4,
	parameter int MT_PER_CYCLE = 20
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst,
	input  wire logic                   i_hold,
	output logic                        o_tick,
	output irq_timers_pkg::macrotick_t  o_mt,
	output irq_timers_pkg::cycle_t      o_cyc,
	output irq_timers_pkg::chan_count_t o_cha,
	output irq_timers_pkg::chan_count_t o_chb
);
	timeunit 1ns;
	timeprecision 1ps;
	int div;
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			div <= 0;
			o_tick <= 1'b0;
			o_mt <= '0;
			o_cyc <= '0;
			o_cha <= 11'h005;
			o_chb <= 11'h7f0;
		end else if (!i_hold) begin
			div <= (div == TICK_DIV - 1) ? 0 : div + 1;
			o_tick <= (div == TICK_DIV - 1);
			o_cha <= o_cha + 11'h001;
			o_chb <= o_chb - 11'h003;
			// Macrotick stays far below 16000; the cycle wraps at 63.
			if (div == TICK_DIV - 1) begin
				o_mt <= (o_mt == MT_PER_CYCLE - 1) ? '0 : o_mt + 14'h0001;
				o_cyc <= (o_mt == MT_PER_CYCLE - 1) ? o_cyc + 6'h01 : o_cyc;
			end
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule // proto_engine_model

// File: test_irq_enable_timers_stopwatch.sv
// Bench for the event block: enables, line gates, stopwatch and timers.
// Assumes the design files and the protocol engine model are compiled.
module test_irq_enable_timers_stopwatch;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
	logic        protocol_state_machine = 1'b1, pin = 1'b0, hold = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, flags = 32'h0, sel = 32'h0, rdata;
	logic        rvalid, line0, line1, cpulse, tpulse, cflag, tflag;
	logic        swev, tick;
	irq_timers_pkg::macrotick_t  mt;
	irq_timers_pkg::cycle_t      cyc;
	irq_timers_pkg::chan_count_t cha, chb;
	int          num_errors = 0, num_checks = 0, cycles = 0;

	irq_enable_timers_stopwatch dut (.i_clock(clock), .i_rst(rst),
		.i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .o_rvalid(rvalid), .i_status_flag_word(flags),
		.i_status_line_select(sel), .i_poc_normal(protocol_state_machine),
		.i_macrotick_tick(tick), .i_macrotick_value(mt),
		.i_cycle_count(cyc), .i_chan_a_count(cha), .i_chan_b_count(chb),
		.i_stopwatch_trigger_pin(pin), .o_irq_line_zero(line0),
		.o_irq_line_one(line1), .o_cycle_timer_pulse_out(cpulse),
		.o_tick_timer_pulse_out(tpulse), .o_cycle_timer_flag(cflag),
		.o_tick_timer_flag(tflag), .o_stopwatch_event(swev));
	proto_engine_model engine (.i_clock(clock), .i_rst(rst), .i_hold(hold),
		.o_tick(tick), .o_mt(mt), .o_cyc(cyc), .o_cha(cha), .o_chb(chb));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	task give_verdict;
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task step;
		@(posedge clock);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		chk(rvalid, 1'b1);
		chk(rdata, exp);
	endtask
	function automatic logic pick(input int w);
		return (w == 0) ? swev : (w == 1) ? cpulse : tpulse;
	endfunction
	task wait_ev(input int w);
		int n;
		n = 0;
		do begin
			step();
			n++;
		end while (pick(w) !== 1'b1 && n < 400);
		chk(pick(w), 1'b1);
	endtask
	// Leaves the protocol outside the normal states; the caller restores it.
	task cut(input int w);
		wait_ev(w);
		@(posedge clock);
		protocol_state_machine <= 1'b0;
		step();
		chk(pick(w), 1'b0);
	endtask

	task t_enables;
		rd(8'h40, 32'h0);
		wr(8'h38, 32'hffffffff);
		rd(8'h38, 32'h0203ffff);
		wr(8'h3c, 32'h00020001);
		rd(8'h3c, 32'h0201fffe);
		wr(8'h38, 32'h0);
		rd(8'h38, 32'h0201fffe);
		wr(8'h3c, 32'hffffffff);
		wr(8'h38, 32'h4);
		rd(8'h5c, 32'h0);
	endtask
	task t_lines;
		wr(8'h40, 32'h1);
		flags <= 32'h4;
		repeat (2) step();
		chk({line1, line0}, 2'b01);
		wr(8'h40, 32'h2);
		repeat (2) step();
		chk({line1, line0}, 2'b00);
		sel <= 32'h4;
		repeat (2) step();
		chk({line1, line0}, 2'b10);
		flags <= 32'h0;
		sel <= 32'h0;
		wr(8'h40, 32'h1);
	endtask
	task t_soft;
		logic [31:0] cap;
		logic [31:0] chw;
		wr(8'h4c, 32'h8);
		wait_ev(0);
		cap = {2'b00, mt, 2'b00, cyc, 8'h00};
		chw = {5'b0, chb, 5'b0, cha};
		rd(8'h4c, cap);
		rd(8'h50, chw);
		hold <= 1'b0;
		repeat (20) @(posedge clock);
		hold <= 1'b1;
		wr(8'h4c, 32'h9);
		repeat (4) @(posedge clock);
		rd(8'h4c, cap);
		rd(8'h50, chw);
	endtask
	task t_pin_line;
		wr(8'h4c, 32'h15);
		pin <= 1'b1;
		wait_ev(0);
		rd(8'h4c, {2'b00, mt, 2'b00, cyc, 8'h14});
		wr(8'h4c, 32'h11);
		pin <= 1'b0;
		wait_ev(0);
		wr(8'h4c, 32'h23);
		flags <= 32'h4;
		wait_ev(0);
		rd(8'h4c, {2'b00, mt, 2'b00, cyc, 8'h23});
		flags <= 32'h0;
		wr(8'h40, 32'h3);
		sel <= 32'h4;
		wr(8'h4c, 32'h43);
		flags <= 32'h4;
		wait_ev(0);
		flags <= 32'h0;
		sel <= 32'h0;
		wr(8'h4c, 32'h0);
	endtask
	task t_cycle;
		int n;
		hold <= 1'b0;
		wr(8'h44, 32'h00030303);
		wait_ev(1);
		chk({cflag, cyc[0], mt}, {2'b11, 14'h0003});
		n = 0;
		while (cpulse === 1'b1 && n < 100) begin
			step();
			n++;
		end
		chk(n, 4);
		cut(1);
		n = 0;
		repeat (200) begin
			step();
			n += (cpulse === 1'b1);
		end
		chk(n, 0);
		@(posedge clock);
		protocol_state_machine <= 1'b1;
		wr(8'h44, 32'h0);
		wr(8'h44, 32'h00030001);
		wait_ev(1);
		repeat (4) step();
		n = 0;
		repeat (200) begin
			step();
			n += (cpulse === 1'b1);
		end
		chk(n, 0);
		wr(8'h44, 32'h0);
	endtask
	task t_tick;
		int n;
		wr(8'h48, 32'h00020001);
		wait_ev(2);
		step();
		chk(tflag, 1'b1);
		n = 0;
		repeat (120) begin
			step();
			n += (tpulse === 1'b1);
		end
		chk(n, 2);
		wr(8'h48, 32'h0);
		wr(8'h48, 32'h00030003);
		wait_ev(2);
		n = 0;
		while (tpulse === 1'b1 && n < 100) begin
			step();
			n++;
		end
		while (tpulse !== 1'b1 && n < 100) begin
			step();
			n++;
		end
		chk(n, 12);
		cut(2);
		@(posedge clock);
		protocol_state_machine <= 1'b1;
		wr(8'h48, 32'h0);
	endtask

	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (30) @(posedge clock);
		hold <= 1'b1;
		t_enables();
		t_lines();
		t_soft();
		t_pin_line();
		t_cycle();
		t_tick();
		give_verdict();
	end
endmodule // test_irq_enable_timers_stopwatch
